// >>> pkg/idrs_defs.vh
/*
  Constants for the identification read and software reset interpreter.
  Assumes it is included by bare name from the design files.
*/
`ifndef IDRS_DEFS_VH
`define IDRS_DEFS_VH

// ------------------------------------------------------------------
// Opcodes and sequence bytes
// ------------------------------------------------------------------
`define IDRS_OP_ID_READ 8'h9f
`define IDRS_OP_RESET 8'hf0
`define IDRS_RESET_TAIL 8'h00
`define IDRS_RESET_BYTES 3'd4

// ------------------------------------------------------------------
// Identification layout
// ------------------------------------------------------------------
`define IDRS_EXT_LEN 8'h01
`define IDRS_ID_BYTES 3'd5
`define IDRS_FAMILY_MSB 7
`define IDRS_FAMILY_LSB 5
`define IDRS_DENSITY_MSB 4
`define IDRS_DENSITY_LSB 0
`define IDRS_REV_MSB 4
`define IDRS_REV_LSB 0

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define IDRS_RST_TERM_NS 30000
`define IDRS_CLK_PERIOD_NS 8

`endif

// >>> rtl/idrs_core.v
/*
  Identification read and four-byte software reset interpreter of a
  serial flash. Assumes the serial pins come from a host master in SPI
  mode 0, asynchronous to core_clk_i; all of them are synchronised here.
*/
`timescale 1ns/1ps
`include "idrs_defs.vh"

// How it works
// - Opcode 9Fh after chip select starts identification output.
// - Manufacturer byte first, then two device-ID bytes in order.
// - Fourth byte is length 01h: one extended byte follows.
// - After the extended byte the output floats; more clocks give nothing.
// - Chip select release ends the read at once and floats the output.
// - Device-ID byte one: family in bits 7..5, density in bits 4..0.
// - Extended byte: reserved bits 7..5, revision in bits 4..0.
// - Reset is F0h plus three 00h bytes; later data is ignored.
// - Valid reset at release aborts program or erase within term time.
// - Reset leaves protection, lockdown and page size untouched.
// - Reset returns both program-suspend flags and erase-suspend to default.
// - Reset during erase suspend abandons the suspended erase.
// - Reset during program suspend abandons the suspended program.
// - No reset if fewer than four bytes or release off a byte boundary.
// - After reset the interpreter is idle and ready for a command.
module idrs_core #(
  parameter [7:0] MANUF_ID = 8'h5a, // Arbitrary identity value.
  parameter [2:0] FAMILY_CODE = 3'h5, // Arbitrary identity value.
  parameter [4:0] DENSITY_CODE = 5'h0a, // Arbitrary identity value.
  parameter [7:0] DEVICE_ID2 = 8'h3c, // Arbitrary identity value.
  parameter [4:0] REVISION = 5'h03, // Arbitrary identity value.
  parameter integer RST_TERM_CYC =
    `IDRS_RST_TERM_NS / `IDRS_CLK_PERIOD_NS
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  output reg so_o,
  output reg so_oe_n_o,
  input wire busy_i,
  input wire erase_susp_i,
  input wire prog_susp_i,
  output reg abort_op_o,
  output reg clear_susp_flags_o,
  output reg abandon_erase_o,
  output reg abandon_prog_o,
  output wire idle_o
);

  // ------------------------------------------------------------------
  // States
  // ------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ID = 4'b0010;
  localparam [3:0] ST_RST = 4'b0100;
  localparam [3:0] ST_IGN = 4'b1000;

  localparam [15:0] TERM_CNT = (RST_TERM_CYC < 1) ? 16'd1 :
    RST_TERM_CYC[15:0];

  // Byte n of the identification answer, assembled from its fields.
  function [7:0] id_byte;
    input [2:0] idx;
    begin
      case (idx)
        3'd0: id_byte = MANUF_ID;
        3'd1: id_byte = {FAMILY_CODE, DENSITY_CODE};
        3'd2: id_byte = DEVICE_ID2;
        3'd3: id_byte = `IDRS_EXT_LEN;
        3'd4: id_byte = {3'b000, REVISION};
        default: id_byte = 8'h00;
      endcase
    end
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------------
  reg [1:0] cs_sync_r;
  reg [1:0] sck_sync_r;
  reg [1:0] si_sync_r;
  reg sck_d_r;
  reg cs_d_r;

  // Two flops per pin; only the second stage feeds any logic.
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cs_sync_r <= 2'b11;
      sck_sync_r <= 2'b00;
      si_sync_r <= 2'b00;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      cs_sync_r <= {cs_sync_r[0], cs_n_i};
      sck_sync_r <= {sck_sync_r[0], sck_i};
      si_sync_r <= {si_sync_r[0], si_i};
      sck_d_r <= sck_sync_r[1];
      cs_d_r <= cs_sync_r[1];
    end
  end

  wire cs_act = ~cs_sync_r[1];
  wire sck_rise = cs_act & sck_sync_r[1] & ~sck_d_r;
  wire sck_fall = cs_act & ~sck_sync_r[1] & sck_d_r;
  wire cs_rise = cs_sync_r[1] & ~cs_d_r;

  // ------------------------------------------------------------------
  // Command interpreter
  // ------------------------------------------------------------------
  reg [3:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [2:0] byte_cnt_r;
  reg [7:0] out_r;
  reg [2:0] out_idx_r;
  reg [15:0] term_cnt_r;
  wire [7:0] rx_byte = {shift_r[6:0], si_sync_r[1]};

  assign idle_o = (state_r == ST_IDLE) & ~cs_act & (term_cnt_r == 16'd0);

  // Inputs sampled on rising serial edges, outputs changed on falling
  // edges so the host sees stable data at its next rising edge.
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'd0;
      shift_r <= 8'h00;
      byte_cnt_r <= 3'd0;
      out_r <= 8'h00;
      out_idx_r <= 3'd0;
      so_o <= 1'b0;
      so_oe_n_o <= 1'b1;
      term_cnt_r <= 16'd0;
      abort_op_o <= 1'b0;
      clear_susp_flags_o <= 1'b0;
      abandon_erase_o <= 1'b0;
      abandon_prog_o <= 1'b0;
    end else begin
      clear_susp_flags_o <= 1'b0;
      abandon_erase_o <= 1'b0;
      abandon_prog_o <= 1'b0;
      // Abort request held for the termination window, then released.
      if (term_cnt_r != 16'd0) begin
        term_cnt_r <= term_cnt_r - 16'd1;
        abort_op_o <= (term_cnt_r != 16'd1);
      end
      if (cs_rise) begin
        // Release: act only on a full, byte-aligned reset sequence.
        if (state_r == ST_RST && byte_cnt_r == `IDRS_RESET_BYTES &&
            bit_cnt_r == 3'd0) begin
          abort_op_o <= busy_i;
          term_cnt_r <= busy_i ? TERM_CNT : 16'd0;
          clear_susp_flags_o <= 1'b1;
          abandon_erase_o <= erase_susp_i;
          abandon_prog_o <= prog_susp_i;
        end
        // Protection and page size are not ours to touch.
        state_r <= ST_IDLE;
        so_oe_n_o <= 1'b1;
        bit_cnt_r <= 3'd0;
        byte_cnt_r <= 3'd0;
      end else if (!cs_act) begin
        state_r <= ST_IDLE;
        so_oe_n_o <= 1'b1;
        bit_cnt_r <= 3'd0;
        byte_cnt_r <= 3'd0;
      end else begin
        if (sck_rise) begin
          shift_r <= rx_byte;
          bit_cnt_r <= bit_cnt_r + 3'd1;
          if (bit_cnt_r == 3'd7) begin
            case (state_r)
              ST_IDLE: begin
                if (rx_byte == `IDRS_OP_ID_READ) begin
                  state_r <= ST_ID;
                  out_r <= id_byte(3'd0);
                  out_idx_r <= 3'd0;
                end else if (rx_byte == `IDRS_OP_RESET) begin
                  state_r <= ST_RST;
                  byte_cnt_r <= 3'd1;
                end else begin
                  state_r <= ST_IGN;
                end
              end
              ST_RST: begin
                if (byte_cnt_r < `IDRS_RESET_BYTES) begin
                  if (rx_byte == `IDRS_RESET_TAIL)
                    byte_cnt_r <= byte_cnt_r + 3'd1;
                  else
                    state_r <= ST_IGN;
                end
                // Bytes past the fourth are ignored.
              end
              default: begin
                state_r <= state_r;
              end
            endcase
          end
        end
        // Drive the next bit on the falling edge.
        if (sck_fall && state_r == ST_ID) begin
          if (out_idx_r < `IDRS_ID_BYTES) begin
            so_oe_n_o <= 1'b0;
            so_o <= out_r[7];
            out_r <= {out_r[6:0], 1'b0};
            if (bit_cnt_r == 3'd7) begin
              out_r <= id_byte(out_idx_r + 3'd1);
              out_idx_r <= out_idx_r + 3'd1;
            end
          end else begin
            so_oe_n_o <= 1'b1;
            so_o <= 1'b0;
          end
        end
      end
    end
  end

endmodule // idrs_core

// >>> test/idrs_core_props.sv
/* Checker for the interpreter's pins.
   Assumes the bench runs RST_TERM_CYC at 4. */
`timescale 1ns/1ps
module idrs_core_props #(
  parameter integer RST_TERM_CYC = 4
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire busy_i,
  input wire so_oe_n_o,
  input wire abort_op_o,
  input wire clear_susp_flags_o,
  input wire abandon_erase_o,
  input wire abandon_prog_o,
  input wire idle_o
);
  // ----
  // Sequences
  // ----
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_pulse;
    clear_susp_flags_o ##1 !clear_susp_flags_o;
  endsequence
  sequence s_float;
    ##[1:4] so_oe_n_o;
  endsequence
  sequence s_clr_busy;
    clear_susp_flags_o && busy_i;
  endsequence
  // The abort window lasts exactly RST_TERM_CYC cycles, then drops.
  sequence s_abort_rise;
    $rose(abort_op_o) && RST_TERM_CYC == 4;
  endsequence
  sequence s_abort_hold;
    abort_op_o [*4] ##1 !abort_op_o;
  endsequence
  AST_CLR_PULSE: assert property (clear_susp_flags_o |-> s_pulse)
    else $error("clear pulse too long");
  AST_ERASE: assert property (abandon_erase_o |-> clear_susp_flags_o)
    else $error("erase abandon without clear");
  AST_PROG: assert property (abandon_prog_o |-> clear_susp_flags_o)
    else $error("program abandon without clear");
  AST_CS_FLOAT: assert property ($rose(cs_n_i) |-> s_float)
    else $error("output still driven");
  AST_IDLE_FLOAT: assert property (cs_n_i [*5] |-> so_oe_n_o)
    else $error("output driven while deselected");
  AST_CLR_CS: assert property (clear_susp_flags_o |-> $past(cs_n_i, 2))
    else $error("clear inside a frame");
  AST_ABORT_BUSY: assert property (s_clr_busy |-> abort_op_o)
    else $error("no abort");
  AST_ABORT_LEN: assert property (s_abort_rise |-> s_abort_hold)
    else $error("abort length wrong");
  AST_ABORT_IDLE: assert property (abort_op_o |-> !idle_o)
    else $error("idle during abort");
endmodule // idrs_core_props

bind idrs_core idrs_core_props #(.RST_TERM_CYC(RST_TERM_CYC))
  idrs_core_props_i (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .busy_i(busy_i), .so_oe_n_o(so_oe_n_o), .abort_op_o(abort_op_o),
  .clear_susp_flags_o(clear_susp_flags_o), .abandon_erase_o(abandon_erase_o),
  .abandon_prog_o(abandon_prog_o), .idle_o(idle_o));

// >>> test/idrs_host_model.sv
/* Host master model of the serial link.
   Assumes SPI mode 0 and a 160 ns serial clock. */
`timescale 1ns/1ps
module idrs_host_model (
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // Shifts n bits MSB first; the clock stands still between frames.
  task automatic frame(input logic [63:0] tx, input int n,
                       output logic [63:0] rx);
    rx = {64{1'bz}};
    cs_n_o = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      si_o = tx[63-i];
      #80 sck_o = 1'b1;
      rx[63-i] = so_i;
      #80 sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    si_o = ~si_o; // A released line must not keep its last value.
    #400;
  endtask
endmodule // idrs_host_model

// >>> test/idrs_core_tb_top.sv
/* Self-checking bench of the interpreter.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`include "idrs_defs.vh"
module idrs_core_tb_top;
  // Identity values below are arbitrary.
  localparam logic [39:0] ID = {8'h6b, 3'h2, 5'h11, 8'h4e, 8'h01, 3'h0, 5'h09};
  // Short abort window so that its full length is seen in a frame gap.
  localparam int TERM = 4;
  logic clk = 0, rst_n = 0, busy = 0, esus = 0, psus = 0;
  logic [31:0] lf = 32'h3d3070bf;
  logic [63:0] rx;
  int fails = 0, tests_run = 0, n_clr = 0, n_ae = 0, n_ap = 0, n_ab = 0;
  wire cs_n, sck, si, so, oe_n, ab, clr, ae, ap, idle;
  wire so_w = oe_n ? 1'bz : so;
  always #4 clk = ~clk;
  idrs_core #(.MANUF_ID(ID[39:32]), .FAMILY_CODE(ID[31:29]),
    .DENSITY_CODE(ID[28:24]), .DEVICE_ID2(ID[23:16]), .REVISION(ID[4:0]),
    .RST_TERM_CYC(TERM)) idrs_core_i (.core_clk_i(clk), .rst_n_i(rst_n),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_n_o(oe_n),
    .busy_i(busy), .erase_susp_i(esus), .prog_susp_i(psus),
    .abort_op_o(ab), .clear_susp_flags_o(clr), .abandon_erase_o(ae),
    .abandon_prog_o(ap), .idle_o(idle));
  idrs_host_model idrs_host_model_i (.cs_n_o(cs_n), .sck_o(sck), .si_o(si),
    .so_i(so_w));
  // Counts the reset side effects of one frame.
  always @(posedge clk) begin
    n_clr += (clr === 1'b1);
    n_ae += (ae === 1'b1);
    n_ap += (ap === 1'b1);
    n_ab += (ab === 1'b1);
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Bits the host should see; a floating output reads as z.
  function logic [63:0] exp_id(input logic [7:0] op, input int n);
    logic [63:0] e;
    e = (op == `IDRS_OP_ID_READ) ? {8'hzz, ID, 16'hzzzz} : {64{1'bz}};
    for (int i = n; i < 64; i++) e[63-i] = 1'bz;
    return e;
  endfunction
  task cmp(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task id_frame(input logic [63:0] tx, input int n);
    idrs_host_model_i.frame(tx, n, rx);
    cmp(rx, exp_id(tx[63:56], n));
  endtask
  // Random suspend and busy state, or all of them set as a corner case;
  // the abort level is expected for the whole TERM window.
  task rst_frame(input logic [63:0] tx, input int n, input logic ok,
                 input logic all1);
    logic [63:0] e;
    @(negedge clk);
    lf = lfsr(lf);
    {busy, esus, psus} = all1 ? 3'b111 : lf[2:0];
    {n_clr, n_ae, n_ap, n_ab} = '0;
    idrs_host_model_i.frame(tx, n, rx);
    e = ok ? 4096 + esus * 256 + psus * 16 + busy * TERM : 0;
    cmp(n_clr * 4096 + n_ae * 256 + n_ap * 16 + n_ab, e);
    cmp({63'h0, idle}, 64'h1);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1;
    repeat (4) @(negedge clk);
    id_frame({8'h9f, 56'h0}, 56);
    id_frame({8'h9f, 56'h0}, 20);
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      id_frame({lf, 32'h0}, 16);
    end
    $display("identification tests done");
    rst_frame(64'hf0000000_00000000, 32, 1, 0);
    rst_frame(64'hf0000000_00000000, 32, 1, 1);
    rst_frame(64'hf0000000_a5000000, 40, 1, 0);
    rst_frame(64'hf0000000_00000000, 24, 0, 0);
    rst_frame(64'hf0000000_00000000, 28, 0, 0);
    rst_frame(64'hf0000000_00000000, 36, 0, 0);
    rst_frame(64'hf0010000_00000000, 32, 0, 0);
    id_frame({8'h9f, 56'h0}, 56);
    $display("reset tests done");
    end_sim;
  end
  // Whole run takes about 0.08 ms; the limit leaves ample margin while
  // staying far below the cycle budget of the run.
  initial begin
    #400000;
    fails++;
    end_sim;
  end
endmodule // idrs_core_tb_top
